// >>> rtl/hfa_buf2.sv
// two-entry valid/ready buffer for result words
// assumes one clock, an asynchronous active-low reset and a clock enable
`timescale 1ns/100ps
module hfa_buf2
   import hfa_pkg::*;
#(
   parameter int WIDTH = 11,
   parameter int DEPTH = 2
)
(
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   input wire logic ce,
   // filling side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // draining side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PW = $clog2(DEPTH);
   typedef struct packed
   {
      logic [DEPTH-1:0][WIDTH-1:0] mem; // word store
      logic [PW-1:0] wp;                // write pointer
      logic [PW-1:0] rp;                // read pointer
      logic [PW:0] cnt;                 // words held
      logic [WIDTH-1:0] dout;           // registered read data
      logic dval;                       // dout holds a word
   } hfa_buf_t;
   hfa_buf_t st;
   hfa_buf_t next_st;
   logic pop;
   logic push;

   // pointer wrap, used by both pointers
   function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
      bump = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
   endfunction

   // occupancy and refill of the output register
   always_comb
   begin
      next_st = st;
      push = in_valid && (st.cnt != (PW+1)'(DEPTH));
      pop = (st.cnt != '0) && (!st.dval || out_ready);
      if (st.dval && out_ready)
      begin
         next_st.dval = 1'b0;
      end
      if (push)
      begin
         next_st.mem[st.wp] = in_data;
         next_st.wp = bump(st.wp);
      end
      if (pop)
      begin
         next_st.dout = st.mem[st.rp];
         next_st.dval = 1'b1;
         next_st.rp = bump(st.rp);
      end
      next_st.cnt = st.cnt + (PW+1)'(push) - (PW+1)'(pop);
   end

   // state register, frozen while ce is low
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         st <= '0;
      end
      else if (ce)
      begin
         st <= next_st;
      end
   end

   assign in_ready = (st.cnt != (PW+1)'(DEPTH));
   assign out_valid = st.dval;
   assign out_data = st.dout;
endmodule

// >>> rtl/hfa_host.sv
// host controller driving a half-flash converter through its pins
// assumes converter pins are synchronous to SYS_CLK; the ready line has a pull-up outside
`timescale 1ns/100ps
module hfa_host
   import hfa_pkg::*;
#(
   parameter int CHAN_BITS = CHAN_W,
   parameter int PIPE_CYC = PIPE_SPACING_CYC,
   parameter int REC_CYC = RECOVERY_CYC,
   parameter int TIMEOUT_CYC = CONV_MAX_CYC
)
(
   // clock, reset, enable
   input wire logic SYS_CLK,
   input wire logic RESETN,
   input wire logic CE,
   // user request side
   input wire logic REQ_VALID,
   input wire logic REQ_PIPELINED,
   input wire logic [CHAN_BITS-1:0] REQ_CHAN,
   output logic REQ_READY,
   // user result side
   output logic RES_VALID,
   input wire logic RES_READY,
   output logic [DATA_W-1:0] RES_DATA,
   output logic [CHAN_BITS-1:0] RES_CHAN,
   output logic RES_TIMEOUT,
   // converter pins
   output logic CS_N,
   output logic RD_N,
   output logic [CHAN_BITS-1:0] CHAN_SEL,
   input wire logic [DATA_W-1:0] RESULT_BUS,
   input wire logic INT_N,
   input wire logic RDY_IN
);
   typedef enum logic [2:0] {S_IDLE, S_WAIT_RUN, S_PIPE_RD, S_PIPE_GAP, S_REC} hfa_state_t;
   typedef struct packed
   {
      hfa_state_t fsm;              // sequencer state
      logic [CNT_W-1:0] cnt;        // cycle counter for spacing and timeout
      logic cs_n;                   // chip select pin
      logic rd_n;                   // read strobe pin
      logic [CHAN_BITS-1:0] chan;   // channel code on the pins
      logic [CHAN_BITS-1:0] prev;   // channel of the conversion in flight
      logic primed;                 // a pipelined conversion is in flight
      logic push;                   // word ready for the buffer
      logic [DATA_W-1:0] data;      // captured byte
      logic [CHAN_BITS-1:0] wchan;  // channel of captured byte
      logic tmo;                    // capture came from a timeout
      logic req_ready;              // request port ready
   } hfa_host_t;
   localparam int BW = DATA_W + CHAN_BITS + 1;
   hfa_host_t st;
   hfa_host_t next_st;
   logic buf_ready;
   logic buf_valid;
   logic [BW-1:0] buf_data;

   // saturating count limit test, used for the timeout, spacing and recovery waits
   function automatic logic reached(input logic [CNT_W-1:0] c, input int lim);
      reached = (c >= CNT_W'(lim - 1));
   endfunction

   // sequencer: one read cycle per request; mode is set purely by strobe length
   always_comb
   begin
      next_st = st;
      // count up but hold at all ones rather than wrap during long idles;
      // done first so that a state clearing the count still wins, or a
      // request taken after a long idle would see its timeout at once
      if (st.cnt != {CNT_W{1'b1}})
      begin
         next_st.cnt = st.cnt + 1'b1;
      end
      // a push stays until the buffer takes it; back-pressure stalls new reads
      if (st.push && buf_ready)
      begin
         next_st.push = 1'b0;
      end
      next_st.req_ready = 1'b0;
      case (st.fsm)
         S_IDLE:
         begin
            next_st.req_ready = !st.push;
            if (REQ_VALID && st.req_ready)
            begin
               next_st.req_ready = 1'b0;
               next_st.cs_n = 1'b0;                       // start conversion
               next_st.rd_n = 1'b0;
               next_st.chan = REQ_CHAN;                   // code 0 means first input
               next_st.cnt = CNT_ZERO;
               next_st.fsm = REQ_PIPELINED ? S_PIPE_RD : S_WAIT_RUN; // strobe length picks mode
            end
         end
         S_WAIT_RUN:
         begin
            // read held low through the whole conversion
            // sample once ready is released and interrupt is low, or at timeout; bus is floating before
            if ((RDY_IN && !INT_N && st.cnt >= CNT_W'(SAMPLE_CYC)) || reached(st.cnt, TIMEOUT_CYC))
            begin
               next_st.data = RESULT_BUS;                 // straight binary byte
               next_st.wchan = st.chan;
               next_st.tmo = !(RDY_IN && !INT_N);
               next_st.primed = 1'b0;                     // bus word now delivered, nothing left to fetch
               next_st.push = 1'b1;
               next_st.cs_n = 1'b1;                       // rising strobe clears interrupt
               next_st.rd_n = 1'b1;
               next_st.cnt = CNT_ZERO;
               next_st.fsm = S_REC;
            end
         end
         S_PIPE_RD:
         begin
            // short read: previous result already on the bus
            if (st.cnt >= CNT_W'(SAMPLE_CYC))
            begin
               if (st.primed)
               begin
                  next_st.data = RESULT_BUS;              // result of earlier read
                  next_st.wchan = st.prev;
                  next_st.tmo = 1'b0;
                  next_st.push = 1'b1;
               end
               next_st.prev = st.chan;
               next_st.primed = 1'b1;
               next_st.cs_n = 1'b1;                       // releases ready and clears interrupt
               next_st.rd_n = 1'b1;
               next_st.fsm = S_PIPE_GAP;
            end
         end
         S_PIPE_GAP:
         begin
            // no new read until conversion done and spacing met
            if ((!INT_N || reached(st.cnt, TIMEOUT_CYC)) && reached(st.cnt, PIPE_CYC))
            begin
               // a conversion that never ended leaves nothing valid to fetch
               if (INT_N)
               begin
                  next_st.primed = 1'b0;
               end
               next_st.cnt = CNT_ZERO;
               next_st.fsm = S_REC;
            end
         end
         S_REC:
         begin
            // recovery after conversion end; ready pull-up is outside
            if (reached(st.cnt, REC_CYC))
            begin
               next_st.fsm = S_IDLE;
            end
         end
         default:
         begin
            next_st.fsm = S_IDLE;
            next_st.cs_n = 1'b1;
            next_st.rd_n = 1'b1;
         end
      endcase
   end

   // state register, frozen while CE is low
   always_ff @(posedge SYS_CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         st <= '0;
         st.fsm <= S_IDLE;
         st.cs_n <= 1'b1;
         st.rd_n <= 1'b1;
      end
      else if (CE)
      begin
         st <= next_st;
      end
   end

   // result buffer: a stalled consumer loses no word
   hfa_buf2 #(.WIDTH(BW), .DEPTH(2)) u_buf
   (
      .clk(SYS_CLK),
      .resetn(RESETN),
      .ce(CE),
      .in_valid(st.push),
      .in_ready(buf_ready),
      .in_data({st.tmo, st.wchan, st.data}),
      .out_valid(buf_valid),
      .out_ready(RES_READY),
      .out_data(buf_data)
   );

   // pins come straight from state flops; buffer outputs are registered inside
   assign CS_N = st.cs_n;
   assign RD_N = st.rd_n;
   assign CHAN_SEL = st.chan;
   assign REQ_READY = st.req_ready;
   assign RES_VALID = buf_valid;
   assign RES_DATA = buf_data[DATA_W-1:0];
   assign RES_CHAN = buf_data[DATA_W +: CHAN_BITS];
   assign RES_TIMEOUT = buf_data[BW-1];
endmodule

// >>> rtl/hfa_pkg.sv
// constants shared by the half-flash converter host controller
// assumes a 100 MHz system clock; all times are converted to cycle counts here
package hfa_pkg;
   localparam int CLK_PERIOD_NS = 10;                 // system clock period
   localparam int PIPE_SPACING_NS = 2500;             // least time between reads, pipelined mode
   localparam int RECOVERY_NS = 500;                  // least time from conversion end to next start
   localparam int CONV_MAX_NS = 4000;                 // longest wait for conversion end before giving up
   // least times round up, longest rounds down
   localparam int PIPE_SPACING_CYC = (PIPE_SPACING_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RECOVERY_CYC = (RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CONV_MAX_CYC = CONV_MAX_NS / CLK_PERIOD_NS;
   localparam int CNT_W = 12;                         // width of the timing counter
   localparam int DATA_W = 8;                         // result byte width
   localparam int CHAN_W = 3;                         // channel code width, eight-channel part
   localparam int SAMPLE_CYC = 2;                     // cycles the bus is sampled after the read strobe
   localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;   // counter reset value
   localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;   // result reset value
   localparam logic [CHAN_W-1:0] CHAN_ZERO = 3'h0;    // channel reset value
endpackage

// >>> sim/hfa_conv_model.sv
// behavioural half-flash converter facing the host controller
// assumes short phase counts; ready line pulled up outside
`timescale 1ns/100ps
module hfa_conv_model
   import hfa_pkg::*;
#(
   parameter int TRACK = 4,
   parameter int LOWER = 3
)
(
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // host pins
   input wire logic cs_n,
   input wire logic rd_n,
   input wire logic [CHAN_W-1:0] chan_sel,
   input wire logic hang,
   output logic [DATA_W-1:0] result_bus,
   output logic int_n,
   output logic rdy_in
);
   logic sel, sel_d, cs_d, rd_d, busy, rdy_low;
   logic [CHAN_W-1:0] chan; // latched channel code
   logic [DATA_W-1:0] out_reg, last; // output latch, last bus value
   int cnt; // internal phase timer, no outside clock
   assign sel = !cs_n && !rd_n;
   // open drain: released line reads high via pull-up
   assign rdy_in = !rdy_low;
   // old word early in a read, new word after end; floating bus toggles
   assign result_bus = (sel && (!busy || cnt < TRACK)) ? out_reg : ~last;
   always_ff @(posedge clk or negedge resetn)
      if (!resetn)
      begin
         {sel_d, busy, rdy_low, chan, out_reg, last, cnt} <= '0;
         {cs_d, rd_d, int_n} <= 3'h7;
      end
      else
      begin
         {sel_d, cs_d, rd_d, last} <= {sel, cs_n, rd_n, result_bus};
         if (sel && !sel_d)
            {busy, cnt, chan} <= {1'b1, 32'h0, chan_sel};
         else if (busy && !hang)
            cnt <= cnt + 1;
         if (busy && cnt == TRACK)
            out_reg[7:4] <= {chan, chan[0]};
         if (busy && cnt == TRACK + LOWER)
            {out_reg[3:0], int_n, busy} <= {chan[0], chan, 2'b00};
         if ((cs_n && !cs_d) || (rd_n && !rd_d))
            int_n <= 1'b1;
         if (!cs_n && cs_d)
            rdy_low <= 1'b1;
         else if (cs_n || (busy && cnt == TRACK + LOWER))
            rdy_low <= 1'b0;
      end
endmodule

// >>> sim/hfa_host_props.sv
// port assertions for the converter host controller
// assumes a bind from the bench, which runs the short timing parameters
`timescale 1ns/100ps
module hfa_host_props
   import hfa_pkg::*;
#(
   parameter int CHAN_BITS = CHAN_W
)
(
   // clock and reset
   input wire logic SYS_CLK,
   input wire logic RESETN,
   input wire logic CE,
   // user side
   input wire logic REQ_VALID,
   input wire logic REQ_PIPELINED,
   input wire logic [CHAN_BITS-1:0] REQ_CHAN,
   input wire logic REQ_READY,
   input wire logic RES_VALID,
   input wire logic RES_READY,
   input wire logic [DATA_W-1:0] RES_DATA,
   // converter pins
   input wire logic CS_N,
   input wire logic RD_N,
   input wire logic [CHAN_BITS-1:0] CHAN_SEL,
   input wire logic INT_N,
   input wire logic RDY_IN
);
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!RESETN);
   logic take; // request accepted this edge
   logic pipe; // mode of the read in flight
   logic [7:0] low; // cycles with read low, saturating
   assign take = REQ_VALID && REQ_READY;
   // helper state: mode and length of the current read
   always_ff @(posedge SYS_CLK or negedge RESETN)
      if (!RESETN)
      begin
         pipe <= 1'b0;
         low <= 8'h00;
      end
      else
      begin
         pipe <= take ? REQ_PIPELINED : pipe;
         low <= RD_N ? 8'h00 : (low == 8'hFF ? low : low + 8'h01);
      end
   property p_start; take |=> !CS_N && !RD_N && CHAN_SEL == $past(REQ_CHAN); endproperty
   a_start: assert property (p_start) else $error("strobe or channel wrong");
   property p_pipe_len; take && REQ_PIPELINED |=> !RD_N [*3] ##1 RD_N; endproperty
   a_pipe_len: assert property (p_pipe_len) else $error("short read length wrong");
   property p_pipe_gap; pipe && $rose(RD_N) |-> RD_N [*5]; endproperty
   a_pipe_gap: assert property (p_pipe_gap) else $error("short reads too close");
   property p_rec; $rose(RD_N) |-> RD_N [*2]; endproperty
   a_rec: assert property (p_rec) else $error("no recovery gap");
   property p_wait_hold; !pipe && !RD_N && !RDY_IN && low < 8'h0F |=> !RD_N; endproperty
   a_wait_hold: assert property (p_wait_hold) else $error("read dropped while busy");
   property p_cap; CE && !pipe && !RD_N && RDY_IN && !INT_N && low > 8'h02 |-> ##[1:4] RD_N; endproperty
   a_cap: assert property (p_cap) else $error("no release after done");
   property p_bound; $fell(RD_N) |-> ##[1:30] RD_N; endproperty
   a_bound: assert property (p_bound) else $error("read never ends");
   property p_res_hold; RES_VALID && !RES_READY |=> RES_VALID && $stable(RES_DATA); endproperty
   a_res_hold: assert property (p_res_hold) else $error("result lost in stall");
   property p_cs_rd; CS_N |-> RD_N; endproperty
   a_cs_rd: assert property (p_cs_rd) else $error("read without select");
endmodule

// >>> sim/testbench.sv
// self-checking bench for the converter host controller
// assumes the converter model and the checker beside it
`timescale 1ns/100ps
module testbench
   import hfa_pkg::*;
;
   // row: mode, channel, word expected, its channel and byte
   typedef struct packed {logic pipe; logic [2:0] ch; logic push; logic [2:0] xch; logic [7:0] xd;} hfa_row_t;
   logic SYS_CLK = 0, RESETN = 0, REQ_VALID = 0, REQ_PIPELINED = 0, RES_READY = 1, hang = 0, mon_on = 1, CE = 1;
   logic [2:0] REQ_CHAN = 3'h0;
   logic REQ_READY, RES_VALID, RES_TIMEOUT, CS_N, RD_N, INT_N, RDY_IN;
   logic [7:0] RES_DATA, RESULT_BUS;
   logic [2:0] RES_CHAN, CHAN_SEL;
   int bad_count = 0, n_tests = 0, cycles = 0;
   logic [10:0] exp_q[$]; // words still owed by the design
   hfa_row_t rows[12] = '{16'h0800, 16'h1939, 16'h2A42, 16'h3B7B, 16'h4C84, 16'h5DBD,
      16'h6EC6, 16'h7FFF, 16'hA000, 16'hDA42, 16'hFDBD, 16'h8FFF};
   hfa_host #(.PIPE_CYC(5), .REC_CYC(2), .TIMEOUT_CYC(20)) u_hfa_host (.SYS_CLK(SYS_CLK), .RESETN(RESETN),
      .CE(CE), .REQ_VALID(REQ_VALID), .REQ_PIPELINED(REQ_PIPELINED), .REQ_CHAN(REQ_CHAN),
      .REQ_READY(REQ_READY), .RES_VALID(RES_VALID), .RES_READY(RES_READY), .RES_DATA(RES_DATA),
      .RES_CHAN(RES_CHAN), .RES_TIMEOUT(RES_TIMEOUT), .CS_N(CS_N), .RD_N(RD_N), .CHAN_SEL(CHAN_SEL),
      .RESULT_BUS(RESULT_BUS), .INT_N(INT_N), .RDY_IN(RDY_IN));
   hfa_conv_model u_hfa_conv_model (.clk(SYS_CLK), .resetn(RESETN), .cs_n(CS_N), .rd_n(RD_N),
      .chan_sel(CHAN_SEL), .hang(hang), .result_bus(RESULT_BUS), .int_n(INT_N), .rdy_in(RDY_IN));
   always #5 SYS_CLK = ~SYS_CLK;
   task automatic check(input logic [11:0] got, input logic [11:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // raise a request off the edge, hold it until an edge takes it
   task automatic request(input logic pipe, input logic [2:0] ch);
      @(negedge SYS_CLK);
      {REQ_VALID, REQ_PIPELINED, REQ_CHAN} = {1'b1, pipe, ch};
      while (REQ_READY !== 1'b1)
         @(negedge SYS_CLK);
      @(negedge SYS_CLK);
      REQ_VALID = 0;
   endtask
   // every word handed over while mon_on is high is compared in order
   always @(posedge SYS_CLK)
      if (mon_on && RES_VALID === 1'b1 && RES_READY)
         check({RES_TIMEOUT, RES_CHAN, RES_DATA}, {1'b0, exp_q.pop_front()});
   // hang guard
   always @(posedge SYS_CLK)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         bad_count++;
         summarize();
      end
   end
   initial
   begin
      repeat (12) @(negedge SYS_CLK);
      check({CS_N, RD_N, REQ_READY, RES_VALID}, 12'h00C);
      RESETN = 1;
      foreach (rows[i])
      begin
         if (rows[i].push)
            exp_q.push_back({rows[i].xch, rows[i].xd});
         request(rows[i].pipe, rows[i].ch);
      end
      // receiver stalls: three words fill buffer and output register, the fourth is held, requests refused
      RES_READY = 0;
      fork
         for (int c = 1; c < 5; c++)
         begin
            exp_q.push_back({rows[c].xch, rows[c].xd});
            request(1'b0, rows[c].ch);
         end
      join_none
      repeat (150) @(negedge SYS_CLK);
      check({11'h000, REQ_READY}, 12'h000);
      RES_READY = 1;
      wait fork;
      repeat (80) @(negedge SYS_CLK);
      // converter never finishes: capture is forced
      {mon_on, hang} = 2'b01;
      request(1'b0, 3'h4);
      while (RES_VALID !== 1'b1)
         @(negedge SYS_CLK);
      check({11'h000, RES_TIMEOUT}, 12'h001);
      hang = 0;
      repeat (2) @(negedge SYS_CLK);
      mon_on = 1;
      RESETN = 0;
      repeat (3) @(negedge SYS_CLK);
      check({CS_N, RD_N, REQ_READY, RES_VALID}, 12'h00C);
      RESETN = 1;
      exp_q.push_back({3'h6, 8'hC6});
      request(1'b0, 3'h6);
      repeat (30) @(negedge SYS_CLK);
      // clock enable low mid-read: pins hold, the word still arrives afterwards
      exp_q.push_back({3'h3, 8'h7B});
      request(1'b0, 3'h3);
      CE = 0;
      repeat (12) @(negedge SYS_CLK);
      check({10'h000, CS_N, RD_N}, 12'h000);
      CE = 1;
      repeat (60) @(negedge SYS_CLK);
      check(12'(exp_q.size()), 12'h000);
      summarize();
   end
endmodule
bind hfa_host hfa_host_props #(.CHAN_BITS(CHAN_BITS)) u_hfa_host_props (.SYS_CLK(SYS_CLK), .RESETN(RESETN),
   .REQ_VALID(REQ_VALID), .REQ_PIPELINED(REQ_PIPELINED), .REQ_CHAN(REQ_CHAN), .REQ_READY(REQ_READY),
   .RES_VALID(RES_VALID), .RES_READY(RES_READY), .RES_DATA(RES_DATA), .CS_N(CS_N), .RD_N(RD_N),
   .CHAN_SEL(CHAN_SEL), .INT_N(INT_N), .RDY_IN(RDY_IN), .CE(CE));
